// *** logic/mmx_map.vh ***
`ifndef MMX_MAP_VH
`define MMX_MAP_VH

// ----------------------------------------------------------------------
// program memory modes (erased configuration reads as all ones)
// ----------------------------------------------------------------------
`define MMX_MODE_MP      2'h3
`define MMX_MODE_EXT     2'h2
`define MMX_MODE_MC      2'h1
`define MMX_MODE_PROT    2'h0

// ----------------------------------------------------------------------
// program memory areas
// ----------------------------------------------------------------------
`define MMX_INT_WORDS    2048
`define MMX_INT_LIMIT    16'h0800
`define MMX_CFG_LO       16'hFE00
`define MMX_UNDEF_WORD   16'hFFFF

// ----------------------------------------------------------------------
// data memory map
// ----------------------------------------------------------------------
`define MMX_ADR_IND0     8'h00
`define MMX_ADR_PTR0     8'h01
`define MMX_ADR_PCL      8'h02
`define MMX_ADR_PROGRAM_COUNTER_HIGH_LATCH   8'h03
`define MMX_ADR_IND1     8'h08
`define MMX_ADR_PTR1     8'h09
`define MMX_ADR_BSR      8'h0F
`define MMX_ADR_BANK_LO  8'h10
`define MMX_ADR_BANK_HI  8'h17
`define MMX_ADR_PGEN_LO  8'h18
`define MMX_ADR_GPR_LO   8'h20

// ----------------------------------------------------------------------
// bank select fields and reset values
// ----------------------------------------------------------------------
`define MMX_BSR_PER_LSB  0
`define MMX_BSR_RAM_LSB  4
`define MMX_BSR_RST      8'h00
`define MMX_PCL_RST      8'h00
`define MMX_PROGRAM_COUNTER_HIGH_LATCH_RST   8'h00

`endif

// *** logic/mmx_mem.v ***
// Notes on behaviour
// - unprogrammed configuration (all ones) selects microprocessor mode.
// - mode gates internal program memory and config/test/boot access.
// - off-chip fetches only in microprocessor and extended modes.
// - data memory accesses are always served on-chip, never on the bus.
// - external modes take the two address/data ports and control port.
// - each bus cycle drives address first, then reads or drives data.
// - extended mode mirrors strobes on internal fetches, ignores bus.
// - bank select applies only to banked locations.
// - peripheral moves use operand 00h-1Fh and file operand 00h-FFh.
// - unused peripheral-range locations act as general storage.
// - all data reachable directly or via two pointers, banked as well.
// - general ram is 8 bits, not initialised, kept across resets.
// - general ram beyond 232 bytes is banked, switched by load_ram_bank.
// - peripheral regs banked, core regs unbanked; load_periph_bank.
// - special function registers are static storage.
// - two configuration bits choose one of four modes.
// - extended mode switches internal/external fetch by address.
// - internal-only modes read undefined data past internal memory.
// - locations 10h-17h banked, other special registers ignore banks.
`timescale 1ns/10ps
`include "mmx_map.vh"

module mmx_mem
(
	input  wire        clk_sys_i,
	input  wire        rst_n_i,
	input  wire [1:0]  cfg_mode_i,
	input  wire        fetch_req_i,
	input  wire        fetch_wr_i,
	input  wire [15:0] fetch_addr_i,
	input  wire [15:0] fetch_wdata_i,
	output reg         fetch_busy_o,
	output reg         fetch_done_o,
	output reg  [15:0] fetch_rdata_o,
	output reg         fetch_ext_o,
	output reg         fetch_blocked_o,
	output reg  [1:0]  mode_o,
	output reg         bus_taken_o,
	input  wire [15:0] ad_i,
	output reg  [15:0] ad_o,
	output reg         ad_oe_o,
	output reg         ale_o,
	output reg         oe_n_o,
	output reg         wr_n_o,
	input  wire        dm_req_i,
	input  wire        dm_we_i,
	input  wire [7:0]  dm_addr_i,
	input  wire [7:0]  dm_wdata_i,
	output reg  [7:0]  dm_rdata_o,
	input  wire        mv_req_i,
	input  wire        mv_to_file_i,
	input  wire [4:0]  mv_periph_i,
	input  wire [7:0]  mv_file_i,
	output reg         mv_done_o,
	input  wire        ldr_req_i,
	input  wire        ldp_req_i,
	input  wire [3:0]  bank_lit_i,
	output reg  [7:0]  bank_select_o
);

// ----------------------------------------------------------------------
// bus cycle states, one clock per q phase
// ----------------------------------------------------------------------
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_Q1   = 5'h02;
localparam [4:0] ST_Q2   = 5'h04;
localparam [4:0] ST_Q3   = 5'h08;
localparam [4:0] ST_Q4   = 5'h10;

reg  [4:0]  state_q;
reg  [15:0] addr_q;
reg  [15:0] wdata_q;
reg         wr_q;
reg         r_ext_q;
reg         r_cfg_q;
reg         r_undef_q;
reg  [1:0]  mode_q;
reg  [15:0] pm_mem [0:`MMX_INT_WORDS-1];

// ----------------------------------------------------------------------
// data memory storage
// ----------------------------------------------------------------------
reg  [7:0]  ptr0_q;
reg  [7:0]  ptr1_q;
reg  [7:0]  pcl_q;
reg  [7:0]  program_counter_high_latch_q;
reg  [7:0]  bsr_q;
reg  [7:0]  core_sfr [0:15];
reg  [7:0]  per_ram  [0:31];
reg  [7:0]  pgen_ram [0:7];
reg  [7:0]  gpr_ram  [0:511];

// ----------------------------------------------------------------------
// fetch routing
// ----------------------------------------------------------------------
wire in_int = fetch_addr_i < `MMX_INT_LIMIT;
wire in_cfg = fetch_addr_i >= `MMX_CFG_LO;
wire is_mp  = mode_q == `MMX_MODE_MP;
wire is_ext = mode_q == `MMX_MODE_EXT;
reg  route_ext;
reg  route_cfg;
reg  route_undef;

always @*
begin
	route_ext   = 1'b0;
	route_cfg   = 1'b0;
	route_undef = 1'b0;
	case (mode_q)
	`MMX_MODE_MP:
		route_ext = 1'b1;
	`MMX_MODE_EXT:
		route_ext = in_cfg | ~in_int;
	default:
	begin
		// internal-only modes never leave the chip
		route_cfg   = in_cfg;
		route_undef = ~in_cfg & ~in_int;
	end
	endcase
end

// ----------------------------------------------------------------------
// data address decode
// ----------------------------------------------------------------------
function [7:0] eff_f;
	input [7:0] a;
	input [7:0] p0;
	input [7:0] p1;
	begin
		if (a == `MMX_ADR_IND0)
			eff_f = p0;
		else if (a == `MMX_ADR_IND1)
			eff_f = p1;
		else
			eff_f = a;
	end
endfunction

function [7:0] rd_f;
	input [7:0] ea;
	begin
		if (ea == `MMX_ADR_IND0 || ea == `MMX_ADR_IND1)
			rd_f = 8'h00;
		else if (ea == `MMX_ADR_PTR0)
			rd_f = ptr0_q;
		else if (ea == `MMX_ADR_PTR1)
			rd_f = ptr1_q;
		else if (ea == `MMX_ADR_PCL)
			rd_f = pcl_q;
		else if (ea == `MMX_ADR_PROGRAM_COUNTER_HIGH_LATCH)
			rd_f = program_counter_high_latch_q;
		else if (ea == `MMX_ADR_BSR)
			rd_f = bsr_q;
		else if (ea < `MMX_ADR_BANK_LO)
			rd_f = core_sfr[ea[3:0]];
		else if (ea <= `MMX_ADR_BANK_HI)
			rd_f = per_ram[{bsr_q[`MMX_BSR_PER_LSB+1:`MMX_BSR_PER_LSB],
				ea[2:0]}];
		else if (ea < `MMX_ADR_GPR_LO)
			rd_f = pgen_ram[ea[2:0]];
		else
			rd_f = gpr_ram[{bsr_q[`MMX_BSR_RAM_LSB], ea}];
	end
endfunction

// ----------------------------------------------------------------------
// one data access per cycle; a move takes the port over
// ----------------------------------------------------------------------
wire [7:0] dm_ea  = eff_f(dm_addr_i, ptr0_q, ptr1_q);
wire [7:0] mv_pa  = eff_f({3'h0, mv_periph_i}, ptr0_q, ptr1_q);
wire [7:0] mv_fa  = eff_f(mv_file_i, ptr0_q, ptr1_q);
wire [7:0] mv_src = mv_to_file_i ? mv_pa : mv_fa;
wire [7:0] mv_dst = mv_to_file_i ? mv_fa : mv_pa;
wire       wr_en  = mv_req_i | (dm_req_i & dm_we_i);
wire [7:0] wr_ea  = mv_req_i ? mv_dst : dm_ea;
wire [7:0] wr_val = mv_req_i ? rd_f(mv_src) : dm_wdata_i;
wire       wr_ind = wr_ea == `MMX_ADR_IND0 || wr_ea == `MMX_ADR_IND1;

// storage arrays carry no reset: contents survive every reset
always @(posedge clk_sys_i)
begin
	if (wr_en && !wr_ind)
	begin
		if (wr_ea < `MMX_ADR_BANK_LO)
			core_sfr[wr_ea[3:0]] <= wr_val;
		else if (wr_ea <= `MMX_ADR_BANK_HI)
			per_ram[{bsr_q[`MMX_BSR_PER_LSB+1:`MMX_BSR_PER_LSB],
				wr_ea[2:0]}] <= wr_val;
		else if (wr_ea < `MMX_ADR_GPR_LO)
			pgen_ram[wr_ea[2:0]] <= wr_val;
		else
			gpr_ram[{bsr_q[`MMX_BSR_RAM_LSB], wr_ea}] <= wr_val;
	end
end

// pointers keep their value across reset, like general ram
always @(posedge clk_sys_i)
begin
	if (wr_en && wr_ea == `MMX_ADR_PTR0)
		ptr0_q <= wr_val;
	if (wr_en && wr_ea == `MMX_ADR_PTR1)
		ptr1_q <= wr_val;
end

always @(posedge clk_sys_i)
begin
	if (!rst_n_i)
	begin
		pcl_q         <= `MMX_PCL_RST;
		program_counter_high_latch_q      <= `MMX_PROGRAM_COUNTER_HIGH_LATCH_RST;
		bsr_q         <= `MMX_BSR_RST;
		bank_select_o <= `MMX_BSR_RST;
		dm_rdata_o    <= 8'h00;
		mv_done_o     <= 1'b0;
	end
	else
	begin
		mv_done_o <= mv_req_i;
		if (dm_req_i && !dm_we_i && !mv_req_i)
			dm_rdata_o <= rd_f(dm_ea);
		if (wr_en && wr_ea == `MMX_ADR_PCL)
			pcl_q <= wr_val;
		if (wr_en && wr_ea == `MMX_ADR_PROGRAM_COUNTER_HIGH_LATCH)
			program_counter_high_latch_q <= wr_val;
		// bank literal loads win over a register write to the same cycle
		if (ldr_req_i)
		begin
			bsr_q[7:4]         <= bank_lit_i;
			bank_select_o[7:4] <= bank_lit_i;
		end
		else if (wr_en && wr_ea == `MMX_ADR_BSR)
		begin
			bsr_q[7:4]         <= wr_val[7:4];
			bank_select_o[7:4] <= wr_val[7:4];
		end
		if (ldp_req_i)
		begin
			bsr_q[3:0]         <= bank_lit_i;
			bank_select_o[3:0] <= bank_lit_i;
		end
		else if (wr_en && wr_ea == `MMX_ADR_BSR)
		begin
			bsr_q[3:0]         <= wr_val[3:0];
			bank_select_o[3:0] <= wr_val[3:0];
		end
	end
end

// ----------------------------------------------------------------------
// internal program memory write, no reset
// ----------------------------------------------------------------------
always @(posedge clk_sys_i)
begin
	if (state_q == ST_Q4 && wr_q && !r_ext_q && !r_cfg_q && !r_undef_q)
		pm_mem[addr_q[10:0]] <= wdata_q;
end

// ----------------------------------------------------------------------
// program bus cycle: q1 address + latch strobe, q2 turn, q3-q4 data
// ----------------------------------------------------------------------
always @(posedge clk_sys_i)
begin
	if (!rst_n_i)
	begin
		// mode bits are caught while reset is held
		mode_q          <= cfg_mode_i;
		mode_o          <= cfg_mode_i;
		bus_taken_o     <= cfg_mode_i == `MMX_MODE_MP ||
			cfg_mode_i == `MMX_MODE_EXT;
		state_q         <= ST_IDLE;
		addr_q          <= 16'h0000;
		wdata_q         <= 16'h0000;
		wr_q            <= 1'b0;
		r_ext_q         <= 1'b0;
		r_cfg_q         <= 1'b0;
		r_undef_q       <= 1'b0;
		fetch_busy_o    <= 1'b0;
		fetch_done_o    <= 1'b0;
		fetch_rdata_o   <= 16'h0000;
		fetch_ext_o     <= 1'b0;
		fetch_blocked_o <= 1'b0;
		ad_o            <= 16'h0000;
		ad_oe_o         <= 1'b0;
		ale_o           <= 1'b0;
		oe_n_o          <= 1'b1;
		wr_n_o          <= 1'b1;
	end
	else
	begin
		fetch_done_o <= 1'b0;
		case (state_q)
		ST_IDLE:
			if (fetch_req_i)
			begin
				state_q         <= ST_Q1;
				addr_q          <= fetch_addr_i;
				wdata_q         <= fetch_wdata_i;
				wr_q            <= fetch_wr_i;
				r_ext_q         <= route_ext;
				r_cfg_q         <= route_cfg;
				r_undef_q       <= route_undef;
				fetch_busy_o    <= 1'b1;
				fetch_ext_o     <= route_ext;
				fetch_blocked_o <= route_undef | (is_ext & in_cfg);
				// strobes run in both external modes, internal or not
				ad_o            <= fetch_addr_i;
				ad_oe_o         <= is_mp | is_ext;
				ale_o           <= is_mp | is_ext;
			end
		ST_Q1:
		begin
			state_q <= ST_Q2;
			ale_o   <= 1'b0;
			// read releases the lines, write drives data
			ad_o    <= wr_q ? wdata_q : 16'h0000;
			ad_oe_o <= wr_q & bus_taken_o;
		end
		ST_Q2:
		begin
			state_q <= ST_Q3;
			oe_n_o  <= ~(~wr_q & bus_taken_o);
			wr_n_o  <= ~(wr_q & bus_taken_o);
		end
		ST_Q3:
		begin
			state_q <= ST_Q4;
			wr_n_o  <= 1'b1;
		end
		ST_Q4:
		begin
			state_q      <= ST_IDLE;
			oe_n_o       <= 1'b1;
			ad_oe_o      <= 1'b0;
			ad_o         <= 16'h0000;
			fetch_busy_o <= 1'b0;
			fetch_done_o <= 1'b1;
			if (r_ext_q)
				fetch_rdata_o <= ad_i;
			else if (r_cfg_q)
				fetch_rdata_o <= {14'h0000, mode_q};
			else if (r_undef_q)
				fetch_rdata_o <= `MMX_UNDEF_WORD;
			else
				fetch_rdata_o <= pm_mem[addr_q[10:0]];
		end
		default:
			state_q <= ST_IDLE;
		endcase
	end
end

endmodule

// *** tb/mmx_ext_mem.sv ***
`timescale 1ns/10ps
module mmx_ext_mem
(
	input  wire        clk_sys_i,
	input  wire [15:0] bus_ad_i,
	input  wire        ale_i,
	input  wire        oe_n_i,
	input  wire        wr_n_i,
	output wire [15:0] bus_ad_o
);
	logic [15:0] mem [0:255];
	logic [15:0] addr_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = {i[7:0] ^ 8'ha5, i[7:0]};
	end
	// released lines toggle so a stale word never passes as read data
	assign bus_ad_o = oe_n_i ? ~last_q : mem[addr_q[7:0]];
	always @(posedge clk_sys_i)
	begin
		last_q <= bus_ad_o;
		if (ale_i)
			addr_q <= bus_ad_i;
		if (!wr_n_i)
			mem[addr_q[7:0]] <= bus_ad_i;
	end
endmodule

// *** tb/mmx_mem_sva.sv ***
`timescale 1ns/10ps
module mmx_mem_sva
(
	input wire        clk_sys_i,
	input wire        rst_n_i,
	input wire        fetch_req_i,
	input wire        fetch_busy_o,
	input wire        fetch_done_o,
	input wire [15:0] fetch_rdata_o,
	input wire        fetch_ext_o,
	input wire        bus_taken_o,
	input wire [15:0] ad_i,
	input wire        ad_oe_o,
	input wire        ale_o,
	input wire        oe_n_o,
	input wire        wr_n_o,
	input wire        mv_req_i,
	input wire        mv_done_o,
	input wire        ldr_req_i,
	input wire [3:0]  bank_lit_i,
	input wire [7:0]  bank_select_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_ale_drive: assert property (
		ale_o |-> ad_oe_o && bus_taken_o)
		else $error("latch strobe without address drive");
	chk_quiet_pins: assert property (
		!bus_taken_o |-> !ale_o && oe_n_o && wr_n_o)
		else $error("strobes active in internal-only mode");
	chk_read_order: assert property (
		$fell(oe_n_o) |-> $past(ale_o, 2) ##1 !oe_n_o ##1 oe_n_o)
		else $error("read strobe out of phase");
	chk_read_data: assert property (
		$rose(oe_n_o) && fetch_ext_o |-> fetch_rdata_o == $past(ad_i))
		else $error("read word not taken from bus");
	chk_write_pulse: assert property (
		$fell(wr_n_o) && fetch_ext_o |-> ad_oe_o ##1 wr_n_o)
		else $error("write strobe wrong");
	chk_busy_span: assert property (
		$rose(fetch_busy_o) |->
			fetch_busy_o [*4] ##1 (fetch_done_o && !fetch_busy_o))
		else $error("bus cycle length wrong");
	chk_ale_cause: assert property (
		ale_o |-> $past(fetch_req_i) && !$past(fetch_busy_o))
		else $error("latch strobe without program access");
	chk_mirror_strobe: assert property (
		$rose(fetch_busy_o) && bus_taken_o |-> ale_o)
		else $error("strobe not mirrored");
	chk_move_done: assert property (
		mv_req_i |=> mv_done_o)
		else $error("move not completed");
	chk_bank_load: assert property (
		ldr_req_i |=> bank_select_o[7:4] == $past(bank_lit_i))
		else $error("ram bank not loaded");
	cover property ($rose(oe_n_o) && fetch_ext_o);
	cover property ($rose(oe_n_o) && !fetch_ext_o && bus_taken_o);
	cover property ($fell(wr_n_o) && fetch_ext_o);
	cover property (mv_req_i);
endmodule
bind mmx_mem mmx_mem_sva i_mmx_mem_sva (.*);

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
	logic        clk_sys_i, rst_n_i, fetch_req_i, fetch_wr_i, dm_req_i;
	logic        dm_we_i, mv_req_i, mv_to_file_i, ldr_req_i, ldp_req_i;
	logic [1:0]  cfg_mode_i;
	logic [3:0]  bank_lit_i;
	logic [4:0]  mv_periph_i;
	logic [7:0]  dm_addr_i, dm_wdata_i, mv_file_i;
	logic [15:0] fetch_addr_i, fetch_wdata_i;
	wire         fetch_busy_o, fetch_done_o, fetch_ext_o, fetch_blocked_o;
	wire         bus_taken_o, ad_oe_o, ale_o, oe_n_o, wr_n_o, mv_done_o;
	wire  [1:0]  mode_o;
	wire  [7:0]  dm_rdata_o, bank_select_o;
	wire  [15:0] fetch_rdata_o, ad_o, ad_i;
	int          fail_count = 0, compares = 0;
	mmx_mem i_mmx_mem (.*);
	mmx_ext_mem i_mmx_ext_mem (.clk_sys_i(clk_sys_i), .bus_ad_i(ad_o),
		.ale_i(ale_o), .oe_n_i(oe_n_o), .wr_n_i(wr_n_o), .bus_ad_o(ad_i));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// --------------------------------------------------------------
	// access tasks
	// --------------------------------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task do_reset(input logic [1:0] m);
		rst_n_i <= 1'b0;
		cfg_mode_i <= m;
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
	endtask
	// reads compare word and {ext, blocked}; writes compare nothing
	task fetch(input logic w, input logic [15:0] a, d, input logic [1:0] f);
		int n;
		n = 0;
		fetch_req_i <= 1'b1;
		fetch_wr_i <= w;
		fetch_addr_i <= a;
		fetch_wdata_i <= d;
		@(posedge clk_sys_i);
		fetch_req_i <= 1'b0;
		do
			@(negedge clk_sys_i);
		while (fetch_done_o !== 1'b1 && ++n < 9);
		if (n == 9)
		begin
			fail_count++;
			$display("BAD %0t no done", $time);
			give_verdict();
		end
		if (!w)
		begin
			chk(fetch_rdata_o, d);
			chk(16'({fetch_ext_o, fetch_blocked_o}), 16'(f));
		end
		@(posedge clk_sys_i);
	endtask
	task dm(input logic w, input logic [7:0] a, input logic [7:0] d);
		dm_req_i <= 1'b1;
		dm_we_i <= w;
		dm_addr_i <= a;
		dm_wdata_i <= d;
		@(posedge clk_sys_i);
		dm_req_i <= 1'b0;
		@(negedge clk_sys_i);
		if (!w)
			chk(16'(dm_rdata_o), 16'(d));
		@(posedge clk_sys_i);
	endtask
	task bank(input logic r, input logic [3:0] v);
		ldr_req_i <= r;
		ldp_req_i <= !r;
		bank_lit_i <= v;
		@(posedge clk_sys_i);
		ldr_req_i <= 1'b0;
		ldp_req_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task mv(input logic t, input logic [4:0] p, input logic [7:0] f);
		mv_req_i <= 1'b1;
		mv_to_file_i <= t;
		mv_periph_i <= p;
		mv_file_i <= f;
		@(posedge clk_sys_i);
		mv_req_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// --------------------------------------------------------------
	// sequence
	// --------------------------------------------------------------
	initial
	begin
		{fetch_req_i, fetch_wr_i, dm_req_i, dm_we_i, mv_req_i} = 5'h00;
		{mv_to_file_i, ldr_req_i, ldp_req_i, bank_lit_i} = 7'h00;
		{mv_periph_i, mv_file_i, dm_addr_i, dm_wdata_i} = 29'h0000_0000;
		{fetch_addr_i, fetch_wdata_i, cfg_mode_i, rst_n_i} = 35'h0_0000_0000;
		do_reset(2'h3);
		chk(16'({bus_taken_o, mode_o}), 16'h0007);
		fetch(1'b0, 16'h0012, 16'hb712, 2'h2);
		fetch(1'b1, 16'h0034, 16'h5a5a, 2'h0);
		fetch(1'b0, 16'h0034, 16'h5a5a, 2'h2);
		dm(1'b1, 8'h20, 8'h11);
		bank(1'b1, 4'h1);
		dm(1'b1, 8'h20, 8'h22);
		dm(1'b0, 8'h20, 8'h22);
		bank(1'b1, 4'h0);
		dm(1'b0, 8'h20, 8'h11);
		bank(1'b0, 4'h1);
		dm(1'b1, 8'h10, 8'h55);
		dm(1'b1, 8'h18, 8'h33);
		bank(1'b0, 4'h0);
		dm(1'b1, 8'h10, 8'h44);
		dm(1'b0, 8'h18, 8'h33);
		bank(1'b0, 4'h1);
		dm(1'b0, 8'h10, 8'h55);
		dm(1'b0, 8'h0f, 8'h01);
		dm(1'b1, 8'h0a, 8'h5c);
		dm(1'b0, 8'h0a, 8'h5c);
		dm(1'b1, 8'h01, 8'h25);
		dm(1'b1, 8'h00, 8'h66);
		dm(1'b0, 8'h25, 8'h66);
		dm(1'b1, 8'h09, 8'h25);
		dm(1'b0, 8'h08, 8'h66);
		mv(1'b1, 5'h18, 8'h40);
		dm(1'b0, 8'h40, 8'h33);
		mv(1'b0, 5'h1f, 8'h20);
		dm(1'b0, 8'h1f, 8'h11);
		do_reset(2'h2);
		dm(1'b0, 8'h20, 8'h11);
		fetch(1'b1, 16'h0100, 16'h1234, 2'h0);
		// overwrite the mirrored word so the internal read must ignore it
		fetch(1'b1, 16'h0800, 16'hbeef, 2'h0);
		fetch(1'b0, 16'h0100, 16'h1234, 2'h0);
		fetch(1'b0, 16'h0900, 16'hbeef, 2'h2);
		fetch(1'b0, 16'hfe10, 16'hb510, 2'h3);
		for (int m = 1; m >= 0; m--)
		begin
			do_reset(m[1:0]);
			chk(16'({bus_taken_o, mode_o}), 16'(m));
			fetch(1'b0, 16'h0100, 16'h1234, 2'h0);
			fetch(1'b0, 16'h0900, 16'hffff, 2'h1);
			fetch(1'b0, 16'hfe00, 16'(m), 2'h0);
		end
		give_verdict();
	end
endmodule
